/* shared/stc_pkg.sv */
// How it works
// - count is 16 bits, readable and writable as high and low bytes.
// - count climbs from 0000 to FFFF and wraps to zero.
// - wrap from all-ones sets a sticky overflow flag, status bit 0.
// - interrupt only raised while overflow enable, mask bit 0, is set.
// - control bit 1 picks external pin (one) or internal clock (zero).
// - timer mode counts once per instruction cycle, system clock over four.
// - counter mode counts rising edges of the external input.
// - counting only while run enable, control bit 0, is one.
// - reset input from either capture/compare unit clears the count.
// - oscillator enabled forces both pins to inputs, reads them as zero.
// - timer mode ignores the synchronisation bit.
// - after enable in counter mode, a falling edge must precede counting.
// - synchronised counter mode prescales first, then synchronises.
// - capture/compare trigger clears count without setting overflow flag.
package stc_pkg;
  // ==========================================================
  // register byte addresses
  localparam logic [7:0] STC_ADDR_CONTROL = 8'h10;
  localparam logic [7:0] STC_ADDR_COUNT_LO = 8'h14;
  localparam logic [7:0] STC_ADDR_COUNT_HI = 8'h18;
  localparam logic [7:0] STC_ADDR_STATUS = 8'h1C;
  localparam logic [7:0] STC_ADDR_MASK = 8'h20;
  localparam logic [7:0] STC_ADDR_DIR = 8'h24;
  localparam logic [7:0] STC_ADDR_PINS = 8'h28;
  // ==========================================================
  // control field positions
  localparam int STC_CTL_RUN = 0;
  localparam int STC_CTL_CLKSEL = 1;
  localparam int STC_CTL_NOSYNC = 2;
  localparam int STC_CTL_OSCEN = 3;
  localparam int STC_CTL_PS_LO = 4;
  localparam logic [7:0] STC_CTL_WMASK = 8'h3F;
  localparam logic [7:0] STC_CTL_RESET = 8'h00;
  localparam logic [1:0] STC_DIR_RESET = 2'h3;
  // ==========================================================
  // timing: instruction cycle is four system clocks
  localparam int STC_INSTR_DIV = 4;
  localparam logic [1:0] STC_INSTR_LAST = 2'(STC_INSTR_DIV - 1);
  // AXI response codes
  localparam logic [1:0] STC_RESP_OKAY = 2'h0;
  localparam logic [1:0] STC_RESP_SLVERR = 2'h2;
endpackage : stc_pkg

/* shared/stc_tick_if.sv */
`timescale 1ns/1ps
`default_nettype none
// prescaler connection: raw count pulses in, prescaled pulses out
interface stc_tick_if;
  logic raw_tick;
  logic clr;
  logic [1:0] ratio;
  logic out_tick;
  modport core (output raw_tick, output clr, output ratio, input out_tick);
  modport presc (input raw_tick, input clr, input ratio, output out_tick);
endinterface : stc_tick_if
`default_nettype wire

/* hdl/stc_prescaler.sv */
`timescale 1ns/1ps
`default_nettype none
module stc_prescaler
(
  input wire logic aclk,
  input wire logic aresetn,
  stc_tick_if.presc tk
);
  logic [2:0] cnt_q;
  logic [2:0] top;
  logic [2:0] cnt_d;
  logic out_q;
  // ==========================================================
  // ratio decode: code n divides by two to the n
  assign top = (3'h1 << tk.ratio) - 3'h1;
  assign cnt_d = (cnt_q >= top) ? 3'h0 : cnt_q + 3'h1;
  // divider; cleared with the count so a trigger restarts the phase
  always_ff @(posedge aclk)
  begin
    if (!aresetn || tk.clr)
    begin
      cnt_q <= 3'h0;
      out_q <= 1'b0;
    end
    else
    begin
      out_q <= tk.raw_tick && (cnt_q >= top);
      if (tk.raw_tick)
        cnt_q <= cnt_d;
    end
  end
  assign tk.out_tick = out_q;
endmodule : stc_prescaler
`default_nettype wire

/* hdl/stc_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module stc_timer
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ccp_one_trigger,
  input wire logic ccp_two_trigger,
  input wire logic external_clock_pin_i,
  input wire logic oscillator_input_pin_i,
  input wire logic [1:0] port_c_pin_out,
  output logic [1:0] port_c_pin_oe,
  output logic osc_inverter_en,
  output logic irq
);
  // ==========================================================
  // state
  logic [7:0] ctl_q;
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic ovf_q;
  logic mask_q;
  logic [1:0] dir_q;
  logic [1:0] pin_s1_q;
  logic [1:0] pin_s2_q;
  logic [1:0] pin_s3_q;
  logic [1:0] pc_s1_q;
  logic [1:0] pc_s2_q;
  logic [1:0] div_q;
  logic armed_q;
  logic run_q;
  logic sync_tick_q;
  logic [1:0] pc_oe_q;
  logic osc_q;
  logic irq_q;
  // bus channel state
  logic aw_q;
  logic w_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  stc_tick_if tk ();
  // ==========================================================
  // control field decode
  wire run_en = ctl_q[stc_pkg::STC_CTL_RUN];
  wire ext_sel = ctl_q[stc_pkg::STC_CTL_CLKSEL];
  wire no_sync = ctl_q[stc_pkg::STC_CTL_NOSYNC];
  wire osc_en = ctl_q[stc_pkg::STC_CTL_OSCEN];
  wire [1:0] ps_sel = ctl_q[stc_pkg::STC_CTL_PS_LO +: 2];
  // ==========================================================
  // pin synchronisers: clock pins and port pins pass two flops before any logic
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_s1_q <= 2'h0;
      pin_s2_q <= 2'h0;
      pin_s3_q <= 2'h0;
      pc_s1_q <= 2'h0;
      pc_s2_q <= 2'h0;
    end
    else
    begin
      pin_s1_q <= {oscillator_input_pin_i, external_clock_pin_i};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pc_s1_q <= port_c_pin_out;
      pc_s2_q <= pc_s1_q;
    end
  end
  // source picked after the synchroniser, so no async mux feeds a flop
  wire ext_now = osc_en ? pin_s2_q[1] : pin_s2_q[0];
  wire ext_prev = osc_en ? pin_s3_q[1] : pin_s3_q[0];
  wire ext_rise = ext_now && !ext_prev;
  wire ext_fall = !ext_now && ext_prev;
  // ==========================================================
  // instruction-cycle divider, one pulse every four clocks
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      div_q <= 2'h0;
    else
      div_q <= (div_q == stc_pkg::STC_INSTR_LAST) ? 2'h0 : div_q + 2'h1;
  end
  wire instr_tick = (div_q == stc_pkg::STC_INSTR_LAST);
  // ==========================================================
  // falling-edge arming after enable in counter mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_q <= 1'b0;
      armed_q <= 1'b0;
    end
    else
    begin
      run_q <= run_en && ext_sel;
      if (!(run_en && ext_sel) || !run_q)
        armed_q <= 1'b0;
      else if (ext_fall)
        armed_q <= 1'b1;
    end
  end
  // ==========================================================
  // raw ticks into the prescaler; an all-digital design cannot run truly
  // unsynchronised, so async mode counts the pin edge with no extra stage
  wire trig = ccp_one_trigger || ccp_two_trigger;
  assign tk.raw_tick = run_en && (ext_sel ? (armed_q && ext_rise) : instr_tick);
  assign tk.clr = trig;
  assign tk.ratio = ps_sel;
  stc_prescaler u_presc
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .tk(tk)
  );
  // synchronised mode resamples after the prescaler; timer mode skips it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sync_tick_q <= 1'b0;
    else
      sync_tick_q <= tk.out_tick && ext_sel && !no_sync;
  end
  wire direct_tick = tk.out_tick && (!ext_sel || no_sync);
  wire inc = (direct_tick || sync_tick_q) && run_en;
  wire wrap = inc && (count_q == 16'hFFFF);
  // ==========================================================
  // bus write decode
  wire wr_go = aw_q && w_q && !bvalid_q;
  wire wr_ctl = wr_go && awaddr_q == stc_pkg::STC_ADDR_CONTROL && wstrb_q[0];
  wire wr_lo = wr_go && awaddr_q == stc_pkg::STC_ADDR_COUNT_LO && wstrb_q[0];
  wire wr_hi = wr_go && awaddr_q == stc_pkg::STC_ADDR_COUNT_HI && wstrb_q[0];
  wire wr_st = wr_go && awaddr_q == stc_pkg::STC_ADDR_STATUS && wstrb_q[0];
  wire wr_mk = wr_go && awaddr_q == stc_pkg::STC_ADDR_MASK && wstrb_q[0];
  wire wr_dir = wr_go && awaddr_q == stc_pkg::STC_ADDR_DIR && wstrb_q[0];
  wire wr_hit = awaddr_q == stc_pkg::STC_ADDR_CONTROL || awaddr_q == stc_pkg::STC_ADDR_COUNT_LO
    || awaddr_q == stc_pkg::STC_ADDR_COUNT_HI || awaddr_q == stc_pkg::STC_ADDR_STATUS
    || awaddr_q == stc_pkg::STC_ADDR_MASK || awaddr_q == stc_pkg::STC_ADDR_DIR;
  // ==========================================================
  // counter: trigger clears, byte writes load, otherwise increment
  always_comb
  begin
    count_d = count_q;
    if (inc)
      count_d = count_q + 16'h0001;
    if (wr_lo)
      count_d[7:0] = wdata_q[7:0];
    if (wr_hi)
      count_d[15:8] = wdata_q[7:0];
    if (trig)
      count_d = 16'h0000;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_q <= 16'h0000;
    else
      count_q <= count_d;
  end
  // ==========================================================
  // registers, overflow flag with set over clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctl_q <= stc_pkg::STC_CTL_RESET;
      ovf_q <= 1'b0;
      mask_q <= 1'b0;
      dir_q <= stc_pkg::STC_DIR_RESET;
    end
    else
    begin
      if (wr_ctl)
        ctl_q <= wdata_q[7:0] & stc_pkg::STC_CTL_WMASK;
      if (wrap && !trig)
        ovf_q <= 1'b1;
      else if (wr_st && wdata_q[0])
        ovf_q <= 1'b0;
      if (wr_mk)
        mask_q <= wdata_q[0];
      if (wr_dir)
        dir_q <= wdata_q[1:0];
    end
  end
  // ==========================================================
  // pin drive, oscillator, interrupt outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pc_oe_q <= 2'h0;
      osc_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      pc_oe_q <= osc_en ? 2'h0 : ~dir_q;
      osc_q <= osc_en;
      irq_q <= ovf_q && mask_q;
    end
  end
  // pins read zero under the oscillator; direction one means input
  wire [1:0] pin_read = osc_en ? 2'h0 : pc_s2_q;
  // ==========================================================
  // axi write channels: address and data taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= stc_pkg::STC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_q)
      begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_q)
      begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? stc_pkg::STC_RESP_OKAY : stc_pkg::STC_RESP_SLVERR;
      end
      if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
        aw_q <= 1'b0;
        w_q <= 1'b0;
      end
    end
  end
  // ==========================================================
  // axi read: one cycle to data
  logic [31:0] rd_mux;
  logic rd_hit;
  always_comb
  begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      stc_pkg::STC_ADDR_CONTROL: rd_mux = {24'h0, ctl_q};
      stc_pkg::STC_ADDR_COUNT_LO: rd_mux = {24'h0, count_q[7:0]};
      stc_pkg::STC_ADDR_COUNT_HI: rd_mux = {24'h0, count_q[15:8]};
      stc_pkg::STC_ADDR_STATUS: rd_mux = {31'h0, ovf_q};
      stc_pkg::STC_ADDR_MASK: rd_mux = {31'h0, mask_q};
      stc_pkg::STC_ADDR_DIR: rd_mux = {30'h0, dir_q};
      stc_pkg::STC_ADDR_PINS: rd_mux = {30'h0, pin_read};
      default:
      begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end
  wire rd_take = s_axi_arvalid && !rvalid_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= stc_pkg::STC_RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_hit ? stc_pkg::STC_RESP_OKAY : stc_pkg::STC_RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end
  // ready strobes are registered-state functions, so outputs follow flops
  assign s_axi_awready = !aw_q;
  assign s_axi_wready = !w_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign port_c_pin_oe = pc_oe_q;
  assign osc_inverter_en = osc_q;
  assign irq = irq_q;
endmodule : stc_timer
`default_nettype wire

/* verif/stc_timer_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ====
// port-level checks of the timer block
module stc_timer_props
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic [1:0] port_c_pin_oe,
  input wire logic osc_inverter_en,
  input wire logic irq
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // only writes with both beats in one edge are tracked; the bench offers them together
  wire aw_t = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire ar_t = s_axi_arvalid && s_axi_arready;
  wire wr_ctl = aw_t && s_axi_awaddr == 8'h10;
  logic mask_q;
  // shadow of the overflow enable bit
  always_ff @(posedge aclk)
    if (!aresetn)
      mask_q <= 1'b0;
    else if (aw_t && s_axi_awaddr == 8'h20)
      mask_q <= s_axi_wdata[0];
  AST_CTL_RSVD: assert property (ar_t && s_axi_araddr == 8'h10 |=> s_axi_rvalid && s_axi_rdata[31:6] == 26'h0)
    else $error("control top bits not zero");
  AST_PIN_ZERO: assert property (ar_t && s_axi_araddr == 8'h28 |=> !osc_inverter_en || s_axi_rdata[1:0] == 2'h0)
    else $error("pins not zero under oscillator");
  AST_OE_OSC: assert property (osc_inverter_en |-> port_c_pin_oe == 2'h0)
    else $error("pin driven under oscillator");
  AST_OSC_ON: assert property (wr_ctl && s_axi_wdata[3] |-> ##[1:5] osc_inverter_en)
    else $error("oscillator not started");
  AST_OSC_OFF: assert property (wr_ctl && !s_axi_wdata[3] |-> ##[1:5] !osc_inverter_en)
    else $error("oscillator not stopped");
  AST_IRQ_MASK: assert property (!mask_q && !$past(mask_q) && !$past(mask_q, 2) |-> !irq)
    else $error("interrupt while masked");
  AST_RD_LAT: assert property (ar_t |=> s_axi_rvalid)
    else $error("read answer late");
  AST_WR_RESP: assert property (aw_t |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  AST_UNMAP: assert property (ar_t && s_axi_araddr == 8'h30 |=> s_axi_rresp == stc_pkg::STC_RESP_SLVERR)
    else $error("unmapped read not refused");
endmodule : stc_timer_props
bind stc_timer stc_timer_props i_stc_timer_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .port_c_pin_oe(port_c_pin_oe), .osc_inverter_en(osc_inverter_en), .irq(irq));
`default_nettype wire

/* verif/stc_clk_src.sv */
`timescale 1ns/1ps
`default_nettype none
// ====
// external clock or crystal source; pins stand still between bursts
module stc_clk_src
(
  output logic ext_pin,
  output logic osc_pin
);
  initial
  begin
    ext_pin = 1'b0;
    osc_pin = 1'b0;
  end
  // half period of four system clocks, slow enough for the pin synchroniser
  task automatic pulses(input logic sel, input int n);
    // step off the clock edge so pin changes never race the synchroniser
    #1;
    repeat (n)
    begin
      #20;
      if (sel) osc_pin = 1'b1;
      else ext_pin = 1'b1;
      #20;
      if (sel) osc_pin = 1'b0;
      else ext_pin = 1'b0;
    end
  endtask : pulses
endmodule : stc_clk_src
`default_nettype wire

/* verif/stc_timer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module stc_timer_bench;
  // ====
  // signals
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic arv = 1'b0;
  logic capture_compare_unit_one = 1'b0;
  logic capture_compare_unit_two = 1'b0;
  logic [1:0] pins = 2'h0;
  wire logic awr, wr_r, bv, arr, rv, osc_en, irq, ext_pin, osc_pin;
  wire logic [1:0] br, rr, oe;
  wire logic [31:0] rdat;
  logic [34:0] rq[$];
  logic [1:0] bq[$];
  logic [34:0] e;
  logic [31:0] lastv, v;
  int bad_count = 0;
  int num_checks = 0;
  int seed = 17;
  int n;
  always #2.5 aclk = ~aclk;
  stc_timer i_stc_timer (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
    .ccp_one_trigger(capture_compare_unit_one), .ccp_two_trigger(capture_compare_unit_two), .external_clock_pin_i(ext_pin),
    .oscillator_input_pin_i(osc_pin), .port_c_pin_out(pins), .port_c_pin_oe(oe),
    .osc_inverter_en(osc_en), .irq(irq));
  stc_clk_src i_stc_clk_src (.ext_pin(ext_pin), .osc_pin(osc_pin));
  // ====
  // tasks
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x)
    begin
      bad_count++;
      $display("FAIL %s exp %h seen %h", nm, x, s);
    end
  endtask : chk
  // ready lines stay high, so only valids and payload move
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    bq.push_back(r);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
    end
    while (!bv);
  endtask : wr
  // x set: data not compared, only kept in lastv
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic x = 1'b0, input logic [1:0] r = 2'h0);
    rq.push_back({x, r, d});
    ara <= a;
    arv <= 1'b1;
    do @(posedge aclk); while (!arr);
    arv <= 1'b0;
    do @(posedge aclk); while (!rv);
    lastv = rdat;
  endtask : rd
  task automatic trig(input logic s);
    capture_compare_unit_one <= !s;
    capture_compare_unit_two <= s;
    @(posedge aclk);
    capture_compare_unit_one <= 1'b0;
    capture_compare_unit_two <= 1'b0;
  endtask : trig
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  // watcher: each answer retires the oldest note
  always @(posedge aclk)
  begin
    if (rv)
    begin
      e = rq.pop_front();
      if (!e[34]) chk("rdata", rdat, e[31:0]);
      chk("rresp", 32'(rr), 32'(e[33:32]));
    end
    if (bv) chk("bresp", 32'(br), 32'(bq.pop_front()));
  end
  // watchdog, far beyond the few thousand cycles the run needs
  initial
  begin
    #100000;
    bad_count++;
    test_done;
  end
  // ====
  // scenarios
  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h0);
    rd(8'h18, 32'h0);
    rd(8'h1C, 32'h0);
    rd(8'h20, 32'h0);
    rd(8'h24, 32'h3);
    rd(8'h30, 32'h0, 1'b0, 2'h2);
    wr(8'h30, 32'h1, 2'h2);
    $display("test reset and map done");
    wr(8'h10, 32'hF8);
    rd(8'h10, 32'h38);
    wr(8'h24, 32'h0);
    pins <= 2'($random(seed));
    repeat (3) @(posedge aclk);
    chk("oe", 32'(oe), 32'h0);
    chk("osc", 32'(osc_en), 32'h1);
    rd(8'h28, 32'h0);
    wr(8'h10, 32'h0);
    repeat (3) @(posedge aclk);
    chk("oe", 32'(oe), 32'h3);
    chk("osc", 32'(osc_en), 32'h0);
    rd(8'h28, 32'(pins));
    $display("test control and pins done");
    v = $random(seed);
    wr(8'h14, v);
    wr(8'h18, v >> 8);
    repeat (40) @(posedge aclk);
    rd(8'h14, v & 32'hFF);
    rd(8'h18, (v >> 8) & 32'hFF);
    wr(8'h14, 32'hFF);
    wr(8'h18, 32'hFF);
    trig(1'b0);
    rd(8'h14, 32'h0);
    rd(8'h18, 32'h0);
    rd(8'h1C, 32'h0);
    $display("test bytes and clear done");
    wr(8'h14, 32'hFE);
    wr(8'h18, 32'hFF);
    wr(8'h20, 32'h1);
    wr(8'h10, 32'h1);
    for (n = 0; n < 64 && irq !== 1'b1; n++) @(posedge aclk);
    chk("irq", 32'(irq), 32'h1);
    wr(8'h10, 32'h0);
    rd(8'h18, 32'h0);
    rd(8'h1C, 32'h1);
    wr(8'h20, 32'h0);
    repeat (3) @(posedge aclk);
    chk("irq", 32'(irq), 32'h0);
    rd(8'h1C, 32'h1);
    wr(8'h1C, 32'h1);
    rd(8'h1C, 32'h0);
    $display("test overflow done");
    // two reads apart by 32 prescaled periods, so phase does not matter
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h10, 32'(k * 16 + 1 + (k % 2) * 4));
      rd(8'h14, 32'h0, 1'b1);
      v = lastv;
      repeat (128 * (1 << k) - 2) @(posedge aclk);
      rd(8'h14, (v + 32) & 32'hFF);
    end
    $display("test timer prescale done");
    // pin idles low, so the first rise is not armed
    for (int k = 0; k < 3; k++)
    begin
      wr(8'h10, 32'h0);
      trig(k[0]);
      rd(8'h14, 32'h0);
      wr(8'h10, k == 0 ? 32'h3 : k == 1 ? 32'h17 : 32'hB);
      i_stc_clk_src.pulses(k == 2, 5);
      repeat (8) @(posedge aclk);
      rd(8'h14, k == 1 ? 32'h2 : 32'h4);
    end
    $display("test counter done");
    test_done;
  end
endmodule : stc_timer_bench
`default_nettype wire
